// >>> dv/fanout_ctrl_asserts.sv
// concurrent checks on the ports of the fanout device control
`timescale 1ns/1ps
module fanout_ctrl_asserts
#(
  parameter PAIRS = 4
)
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_ref_sel_pin_hi,
  input wire i_ref_sel_pin_lo,
  input wire i_output_enable,
  input wire i_reg_write,
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [PAIRS-1:0] i_pair_a_disable,
  input wire [7:0] o_reg_rdata,
  input wire o_bank_a_clk,
  input wire o_bank_b_clk,
  input wire [PAIRS-1:0] o_bank_a_drive,
  input wire [PAIRS-1:0] o_bank_a_pair_power,
  input wire o_divider_a_power,
  input wire o_divider_b_power,
  input wire o_bank_a_supply_hint,
  input wire o_bank_b_supply_hint,
  input wire o_divider_a_on_one,
  input wire o_divider_b_on_one
);
  reg [7:0] ctl;
  // write decodes and the source each divider should be on in forced mode
  wire wr0 = i_reg_write && i_reg_addr == 4'h0;
  wire wr1 = i_reg_write && i_reg_addr == 4'h1;
  wire want_a = ctl[4] ? ctl[5] : i_ref_sel_pin_lo;
  wire want_b = ctl[4] ? ctl[6] : i_ref_sel_pin_hi;
  // shadow of the reference byte; only the mode and select bits matter here
  always @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      ctl <= 8'h00;
    else if (wr0)
      ctl <= i_reg_wdata;
  default clocking dclk @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_FORCED_SEL:
  assert property ((!ctl[7] && $stable({want_b, want_a}))[*3] |=>
    {o_divider_b_on_one, o_divider_a_on_one} == $past({want_b, want_a}))
    else $error("divider source does not follow forced selection");
  AST_READBACK:
  assert property (wr0 ##1 (i_reg_addr == 4'h0) |=>
    o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hf1))
    else $error("reference byte read back wrong");
  AST_DIV_POWER:
  assert property (wr1 |-> ##2
    {o_divider_a_power, o_divider_b_power} == ~$past(i_reg_wdata[1:0], 2))
    else $error("divider power does not match its bits");
  AST_SUPPLY_HINT:
  assert property (wr1 |-> ##2
    {o_bank_a_supply_hint, o_bank_b_supply_hint} == $past(i_reg_wdata[7:6], 2))
    else $error("supply hints not stored");
  AST_PAIR_POWER:
  assert property (wr1 |-> ##2 o_bank_a_pair_power ==
    (~$past(i_pair_a_disable) & {PAIRS{~$past(i_reg_wdata[3], 2)}}))
    else $error("bank a pair power wrong");
  AST_HOLD:
  assert property (wr0 && i_reg_wdata[0] ##1 (!i_reg_write)[*3] |=>
    !o_bank_a_clk && !o_bank_b_clk)
    else $error("bank clock runs while dividers held");
  AST_QUIET:
  assert property (wr1 && i_reg_wdata[5] ##1 (!i_reg_write && !o_bank_a_clk)[*3] |=>
    o_bank_a_drive == '0)
    else $error("quiet bank a still driven");
  AST_OE_OFF:
  assert property ((!i_output_enable && !o_bank_a_clk)[*3] |=> o_bank_a_drive == '0)
    else $error("bank a driven with enable pin low");
  AST_DRIVE_AT_LOW:
  assert property (!$stable(o_bank_a_drive) |-> !o_bank_a_clk || !$past(o_bank_a_clk))
    else $error("bank a drive changed inside a high phase");
  // main scenarios reached
  cover property (wr0 && i_reg_wdata[7]);
  cover property ($rose(o_divider_a_on_one));
  cover property ($rose(o_bank_a_clk) && $rose(o_bank_b_clk));
endmodule

bind fanout_device_control fanout_ctrl_asserts #(.PAIRS(PAIRS)) u_asserts (.*);

// >>> dv/tb_top.sv
// self-checking bench for the fanout device control
`timescale 1ns/1ps
module tb_top;
  reg i_clock = 1'b0;
  reg i_rst_n = 1'b0;
  reg r0 = 1'b0, r1 = 1'b0, hi = 1'b0, lo = 1'b0, oe = 1'b1, we = 1'b0, run = 1'b0;
  reg [3:0] addr = 4'h0, pda = 4'h0, pdb = 4'h0;
  reg [7:0] wd = 8'h00;
  reg [8:0] rta = 9'h000, rtb = 9'h000;
  wire [7:0] rdata;
  wire ca, cb, pwa, pwb, hna, hnb, ona, onb;
  wire [3:0] dra, drb, ppa, ppb;
  integer mismatches = 0, n_compared = 0, t = 0, k, m, hr = 0, minh, na = 0, nb = 0;
  always #5 i_clock = ~i_clock;
  // references: period 8 and 12 clocks, parked low when stopped
  always @(negedge i_clock)
  begin
    t <= t + 1;
    r0 <= run & (t % 8 < 4);
    r1 <= run & (t % 12 < 6);
  end
  // shortest high phase of bank a, a cut pulse shows up here
  always @(posedge i_clock)
    if (ca)
      hr <= hr + 1;
    else
    begin
      if (hr > 0 && hr < minh)
        minh <= hr;
      hr <= 0;
    end
  always @(posedge ca) na = na + 1;
  always @(posedge cb) nb = nb + 1;
  fanout_device_control uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ref_input_zero(r0),
    .i_ref_input_one(r1), .i_ref_sel_pin_hi(hi), .i_ref_sel_pin_lo(lo), .i_output_enable(oe),
    .i_reg_write(we), .i_reg_addr(addr), .i_reg_wdata(wd), .i_pair_a_disable(pda),
    .i_pair_b_disable(pdb), .i_divider_a_ratio(rta), .i_divider_b_ratio(rtb),
    .o_reg_rdata(rdata), .o_bank_a_clk(ca), .o_bank_b_clk(cb), .o_bank_a_drive(dra),
    .o_bank_b_drive(drb), .o_bank_a_pair_power(ppa), .o_bank_b_pair_power(ppb),
    .o_divider_a_power(pwa), .o_divider_b_power(pwb), .o_bank_a_supply_hint(hna),
    .o_bank_b_supply_hint(hnb), .o_divider_a_on_one(ona), .o_divider_b_on_one(onb));
  task report_and_stop;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task w(input integer c);
    repeat (c) @(negedge i_clock);
  endtask
  // one write strobe, launched and dropped on falling edges
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(negedge i_clock);
    we = 1'b1;
    addr = a;
    wd = d;
    @(negedge i_clock);
    we = 1'b0;
  end
  endtask
  task rdc(input [3:0] a, input [7:0] e);
  begin
    @(negedge i_clock);
    addr = a;
    @(negedge i_clock);
    chk(rdata, e);
  end
  endtask
  task t_reset;
  begin
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(4'h7, 8'h00);
    chk({pwa, pwb, hna, hnb, ppa, ppb, dra, drb}, {4'hc, 16'hffff});
    $display("test reset done");
  end
  endtask
  task t_regs;
  begin
    wr(4'h0, 8'hf1);
    rdc(4'h0, 8'hf1);
    pda = 4'h5;
    wr(4'h1, 8'hc6);
    w(4);
    chk({hna, hnb, pwa, pwb}, 4'hd);
    chk({ppa, ppb}, 8'ha0);
    rdc(4'h1, 8'hc6);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    pda = 4'h0;
    $display("test registers done");
  end
  endtask
  task t_select;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(4'h0, {1'b0, k[1:0], 5'h10});
      w(4);
      chk({onb, ona}, k[1:0]);
    end
    wr(4'h0, 8'h60);
    for (k = 0; k < 4; k = k + 1)
    begin
      hi = k[1];
      lo = k[0];
      w(4);
      chk({onb, ona}, k[1:0]);
    end
    hi = 1'b0;
    lo = 1'b0;
    wr(4'h0, 8'h00);
    $display("test select done");
  end
  endtask
  task t_glitch;
  begin
    run = 1'b1;
    wr(4'h0, 8'h80);
    w(20);
    minh = 99;
    lo = 1'b1;
    for (k = 0; k < 100 && ona !== 1'b1; k = k + 1)
      @(negedge i_clock);
    chk(ona, 1'b1);
    if (ona !== 1'b1)
      report_and_stop;
    w(40);
    chk(minh >= 4, 1);
    wr(4'h0, 8'h00);
    lo = 1'b0;
    w(6);
    $display("test glitchless done");
  end
  endtask
  task t_divide;
  begin
    rta = 9'h004;
    rtb = 9'h001;
    w(40);
    na = 0;
    nb = 0;
    w(320);
    chk(na >= 9 && na <= 11, 1);
    chk(nb >= 39 && nb <= 41, 1);
    rtb = 9'h004;
    wr(4'h0, 8'h01);
    w(10);
    na = 0;
    nb = 0;
    w(64);
    chk(na + nb + ca + cb, 0);
    wr(4'h0, 8'h00);
    m = 0;
    repeat (200)
    begin
      @(negedge i_clock);
      if (ca !== cb)
        m = m + 1;
    end
    chk(m, 0);
    chk(na >= 5, 1);
    rta = 9'h000;
    rtb = 9'h000;
    run = 1'b0;
    w(20);
    $display("test divider done");
  end
  endtask
  task t_drive;
  begin
    pda = 4'h2;
    w(6);
    chk({dra, ppa, drb}, 12'hddf);
    wr(4'h1, 8'h28);
    w(6);
    chk({dra, ppa, drb}, 12'h00f);
    wr(4'h1, 8'h20);
    w(6);
    chk({dra, ppa}, 8'h0d);
    wr(4'h1, 8'h00);
    w(6);
    chk(dra, 4'hd);
    oe = 1'b0;
    w(6);
    chk({dra, drb}, 8'h00);
    oe = 1'b1;
    pda = 4'h0;
    w(6);
    chk({dra, drb}, 8'hff);
    $display("test drive done");
  end
  endtask
  initial
  begin
    repeat (20) @(negedge i_clock);
    i_rst_n = 1'b1;
    w(2);
    t_reset;
    t_regs;
    t_select;
    t_glitch;
    t_divide;
    t_drive;
    report_and_stop;
  end
endmodule

// >>> include/fanout_ctrl_regs.vh
// register offsets, field positions, reset values, selection codes and divider ratio limits for the fanout control
`ifndef FANOUT_CTRL_REGS_VH
`define FANOUT_CTRL_REGS_VH
`define REG_ADDR_W 4
`define REG_DATA_W 8
`define REF_SYNC_CTRL_OFFSET 4'h0
`define BANK_PWR_CTRL_OFFSET 4'h1
`define REF_SYNC_CTRL_RESET 8'h00
`define BANK_PWR_CTRL_RESET 8'h00
`define REF_SYNC_CTRL_MASK 8'hf1
`define BIT_SWITCHOVER_MODE 7
`define BIT_REF_SEL_HI 6
`define BIT_REF_SEL_LO 5
`define BIT_SEL_SOURCE 4
`define BIT_DIV_HOLD 0
`define BIT_BANK_A_SUPPLY_HINT 7
`define BIT_BANK_B_SUPPLY_HINT 6
`define BIT_BANK_A_QUIET_DISABLE 5
`define BIT_BANK_B_QUIET_DISABLE 4
`define BIT_BANK_A_OUTPUT_POWER_OFF 3
`define BIT_BANK_B_OUTPUT_POWER_OFF 2
`define BIT_DIVIDER_A_POWER_DOWN 1
`define BIT_DIVIDER_B_POWER_DOWN 0
`define SEL_BOTH_ZERO 2'h0
`define SEL_A_ONE_B_ZERO 2'h1
`define SEL_A_ZERO_B_ONE 2'h2
`define SEL_BOTH_ONE 2'h3
`define DIV_RATIO_W 9
`define DIV_RATIO_RESET 9'h000
`define DIV_BYPASS_MAX 9'h001
`endif

// >>> rtl/bank_divider.v
// integer output divider for one bank with hold, power-down and bypass
`timescale 1ns/1ps
`include "fanout_ctrl_regs.vh"
module bank_divider
#(
  parameter RATIO_W = `DIV_RATIO_W
)
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_ref_clk,
  input wire i_hold,
  input wire i_power_down,
  input wire [RATIO_W-1:0] i_ratio,
  output reg o_div_clk
);
  reg prev_ref;
  reg [RATIO_W-1:0] count;
  wire ref_rise;
  wire bypass;
  wire [RATIO_W-1:0] half;

  assign ref_rise = i_ref_clk & ~prev_ref;
  assign bypass = (i_ratio <= `DIV_BYPASS_MAX);
  assign half = i_ratio >> 1;

  // counts rising reference edges; the output is high for ratio/2 edges of every ratio
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_ref <= 1'b0;
      count <= {RATIO_W{1'b0}};
      o_div_clk <= 1'b0;
    end
    else
    begin
      prev_ref <= i_ref_clk;
      if (i_hold || (i_power_down && !bypass))
      begin
        count <= {RATIO_W{1'b0}};
        o_div_clk <= 1'b0;
      end
      else if (bypass)
        o_div_clk <= i_ref_clk;
      else if (ref_rise)
      begin
        // high for ratio/2 rising edges, low for the rest
        if (count == i_ratio - 1'b1)
          count <= {RATIO_W{1'b0}};
        else
          count <= count + 1'b1;
        o_div_clk <= (count == i_ratio - 1'b1) || (count < half - 1'b1);
      end
    end
  end
endmodule

// >>> rtl/fanout_device_control.v
// device-control registers and reference routing for the two-bank clock fanout
`timescale 1ns/1ps
`include "fanout_ctrl_regs.vh"
// How it works
// - mode 0: reference source changes at once, glitches accepted
// - mode 1: switch without glitches, may stay on a dead old source
// - select 00 zero/zero, 01 A one, 10 B one, 11 one/one
// - register select field used only while selection-source bit is 1
// - source bit 0 uses select pin, 1 uses register field
// - hold bit 1 resets both dividers and stops their clocks
// - hold 1 to 0 releases both dividers in the same cycle
// - quiet-disable 0 enables bank outputs per pair without runt pulses
// - quiet-disable 1 forces every output of that bank to high impedance
// - output power-off 1 powers bank outputs off, 0 powers them
// - divider power-down 1 powers that bank divider down
// - each bank stores a supply hint bit, 0 means 3.3 V
// - ratio 0 or 1 bypasses, 2 to 511 divides by the value
// - enable pin low tri-states all outputs, changes without runt pulses
// - pair disable 1 powers that pair down, 0 enables it
module fanout_device_control
#(
  parameter PAIRS = 4,
  parameter RATIO_W = `DIV_RATIO_W
)
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_ref_input_zero,
  input wire i_ref_input_one,
  input wire i_ref_sel_pin_hi,
  input wire i_ref_sel_pin_lo,
  input wire i_output_enable,
  input wire i_reg_write,
  input wire [`REG_ADDR_W-1:0] i_reg_addr,
  input wire [`REG_DATA_W-1:0] i_reg_wdata,
  input wire [PAIRS-1:0] i_pair_a_disable,
  input wire [PAIRS-1:0] i_pair_b_disable,
  input wire [RATIO_W-1:0] i_divider_a_ratio,
  input wire [RATIO_W-1:0] i_divider_b_ratio,
  output reg [`REG_DATA_W-1:0] o_reg_rdata,
  output reg o_bank_a_clk,
  output reg o_bank_b_clk,
  output reg [PAIRS-1:0] o_bank_a_drive,
  output reg [PAIRS-1:0] o_bank_b_drive,
  output reg [PAIRS-1:0] o_bank_a_pair_power,
  output reg [PAIRS-1:0] o_bank_b_pair_power,
  output reg o_divider_a_power,
  output reg o_divider_b_power,
  output reg o_bank_a_supply_hint,
  output reg o_bank_b_supply_hint,
  output reg o_divider_a_on_one,
  output reg o_divider_b_on_one
);
  reg [`REG_DATA_W-1:0] reference_and_sync_control;
  reg [`REG_DATA_W-1:0] bank_power_and_enable_control;
  reg oe_sync;
  reg [1:0] next_sel;
  reg [PAIRS-1:0] next_a_drive;
  reg [PAIRS-1:0] next_b_drive;
  reg [PAIRS-1:0] next_a_pair_power;
  reg [PAIRS-1:0] next_b_pair_power;
  wire switchover_mode;
  wire sel_source;
  wire div_hold;
  wire bank_a_quiet_disable;
  wire bank_b_quiet_disable;
  wire bank_a_output_power_off;
  wire bank_b_output_power_off;
  wire divider_a_power_down;
  wire divider_b_power_down;
  wire ref_a;
  wire ref_b;
  wire div_a_clk;
  wire div_b_clk;
  wire mux_a_one;
  wire mux_b_one;
  wire a_low_edge;
  wire b_low_edge;
  wire [1:0] reg_sel;
  wire mux_a_on_one_w;
  wire mux_b_on_one_w;

  // drive mask for one bank: global enable, bank quiet-disable, pair disable and power
  function [PAIRS-1:0] bank_drive;
    input oe;
    input quiet;
    input power_off;
    input [PAIRS-1:0] pair_dis;
    begin
      bank_drive = (oe && !quiet && !power_off) ? ~pair_dis : {PAIRS{1'b0}};
    end
  endfunction

  // powered pairs of one bank: bank power-off wins over the per-pair bits
  function [PAIRS-1:0] pair_power;
    input power_off;
    input [PAIRS-1:0] pair_dis;
    begin
      pair_power = power_off ? {PAIRS{1'b0}} : ~pair_dis;
    end
  endfunction

  // true when a selection code routes input one to divider b (for_b set) or divider a
  function routes_input_one;
    input [1:0] sel;
    input for_b;
    begin
      case (sel)
        `SEL_BOTH_ZERO: routes_input_one = 1'b0;
        `SEL_A_ONE_B_ZERO: routes_input_one = !for_b;
        `SEL_A_ZERO_B_ONE: routes_input_one = for_b;
        `SEL_BOTH_ONE: routes_input_one = 1'b1;
        default: routes_input_one = 1'b0;
      endcase
    end
  endfunction

  // fields of the reference byte
  assign switchover_mode = reference_and_sync_control[`BIT_SWITCHOVER_MODE];
  assign sel_source = reference_and_sync_control[`BIT_SEL_SOURCE];
  assign reg_sel = reference_and_sync_control[`BIT_REF_SEL_HI:`BIT_REF_SEL_LO];
  assign div_hold = reference_and_sync_control[`BIT_DIV_HOLD];

  // fields of the bank byte
  assign bank_a_quiet_disable = bank_power_and_enable_control[`BIT_BANK_A_QUIET_DISABLE];
  assign bank_b_quiet_disable = bank_power_and_enable_control[`BIT_BANK_B_QUIET_DISABLE];
  assign bank_a_output_power_off = bank_power_and_enable_control[`BIT_BANK_A_OUTPUT_POWER_OFF];
  assign bank_b_output_power_off = bank_power_and_enable_control[`BIT_BANK_B_OUTPUT_POWER_OFF];
  assign divider_a_power_down = bank_power_and_enable_control[`BIT_DIVIDER_A_POWER_DOWN];
  assign divider_b_power_down = bank_power_and_enable_control[`BIT_DIVIDER_B_POWER_DOWN];

  // selection source: pin when the source bit is clear, register field when set;
  // the register field is ignored entirely while the pin is in charge
  always @*
  begin
    case (sel_source)
      1'b1: next_sel = reg_sel;
      default: next_sel = {i_ref_sel_pin_hi, i_ref_sel_pin_lo};
    endcase
  end

  // both dividers decode the same code, each looking up its own column
  assign mux_a_one = routes_input_one(next_sel, 1'b0);
  assign mux_b_one = routes_input_one(next_sel, 1'b1);

  // reference byte; reserved bits are dropped so they always read back zero
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      reference_and_sync_control <= `REF_SYNC_CTRL_RESET;
    else if (i_reg_write && (i_reg_addr == `REF_SYNC_CTRL_OFFSET))
      reference_and_sync_control <= i_reg_wdata & `REF_SYNC_CTRL_MASK;
  end

  // bank byte; every bit is a live control, so the whole byte is stored
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      bank_power_and_enable_control <= `BANK_PWR_CTRL_RESET;
    else if (i_reg_write && (i_reg_addr == `BANK_PWR_CTRL_OFFSET))
      bank_power_and_enable_control <= i_reg_wdata;
  end

  // read data is registered; unmapped offsets read zero
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= {`REG_DATA_W{1'b0}};
    else
    begin
      case (i_reg_addr)
        `REF_SYNC_CTRL_OFFSET: o_reg_rdata <= reference_and_sync_control;
        `BANK_PWR_CTRL_OFFSET: o_reg_rdata <= bank_power_and_enable_control;
        default: o_reg_rdata <= {`REG_DATA_W{1'b0}};
      endcase
    end
  end

  glitchless_ref_mux mux_a
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ref_zero(i_ref_input_zero),
    .i_ref_one(i_ref_input_one),
    .i_want_one(mux_a_one),
    .i_glitchless(switchover_mode),
    .o_ref_clk(ref_a),
    .o_on_one(mux_a_on_one_w)
  );

  glitchless_ref_mux mux_b
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ref_zero(i_ref_input_zero),
    .i_ref_one(i_ref_input_one),
    .i_want_one(mux_b_one),
    .i_glitchless(switchover_mode),
    .o_ref_clk(ref_b),
    .o_on_one(mux_b_on_one_w)
  );

  // one shared hold bit feeds both dividers, so release lands on the same edge
  bank_divider #(.RATIO_W(RATIO_W)) divider_a
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ref_clk(ref_a),
    .i_hold(div_hold),
    .i_power_down(divider_a_power_down),
    .i_ratio(i_divider_a_ratio),
    .o_div_clk(div_a_clk)
  );

  bank_divider #(.RATIO_W(RATIO_W)) divider_b
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_ref_clk(ref_b),
    .i_hold(div_hold),
    .i_power_down(divider_b_power_down),
    .i_ratio(i_divider_b_ratio),
    .o_div_clk(div_b_clk)
  );

  // enable changes only take effect while the bank clock is low, so no runt pulse;
  // a bank whose clock sticks high keeps its last drive mask until the clock drops
  assign a_low_edge = !div_a_clk;
  assign b_low_edge = !div_b_clk;

  // values the drive and power registers take next
  always @*
  begin
    next_a_drive = bank_drive(oe_sync, bank_a_quiet_disable, bank_a_output_power_off,
      i_pair_a_disable);
    next_b_drive = bank_drive(oe_sync, bank_b_quiet_disable, bank_b_output_power_off,
      i_pair_b_disable);
    next_a_pair_power = pair_power(bank_a_output_power_off, i_pair_a_disable);
    next_b_pair_power = pair_power(bank_b_output_power_off, i_pair_b_disable);
  end

  // bank clocks and source flags; the extra stage keeps every output on a flip-flop
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bank_a_clk <= 1'b0;
      o_bank_b_clk <= 1'b0;
      o_divider_a_on_one <= 1'b0;
      o_divider_b_on_one <= 1'b0;
    end
    else
    begin
      o_bank_a_clk <= div_a_clk;
      o_bank_b_clk <= div_b_clk;
      o_divider_a_on_one <= mux_a_on_one_w;
      o_divider_b_on_one <= mux_b_on_one_w;
    end
  end

  // the enable pin is retimed once so its change lines up with the bank clock stage
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      oe_sync <= 1'b0;
    else
      oe_sync <= i_output_enable;
  end

  // bank a drive mask, sampled only in the low phase of its own clock
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bank_a_drive <= {PAIRS{1'b0}};
    else if (a_low_edge)
      o_bank_a_drive <= next_a_drive;
  end

  // bank b drive mask, gated by its own clock so the banks never wait on each other
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bank_b_drive <= {PAIRS{1'b0}};
    else if (b_low_edge)
      o_bank_b_drive <= next_b_drive;
  end

  // pair and divider power, and the stored supply hints
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bank_a_pair_power <= {PAIRS{1'b0}};
      o_bank_b_pair_power <= {PAIRS{1'b0}};
      o_divider_a_power <= 1'b0;
      o_divider_b_power <= 1'b0;
      o_bank_a_supply_hint <= 1'b0;
      o_bank_b_supply_hint <= 1'b0;
    end
    else
    begin
      o_bank_a_pair_power <= next_a_pair_power;
      o_bank_b_pair_power <= next_b_pair_power;
      o_divider_a_power <= !divider_a_power_down;
      o_divider_b_power <= !divider_b_power_down;
      o_bank_a_supply_hint <= bank_power_and_enable_control[`BIT_BANK_A_SUPPLY_HINT];
      o_bank_b_supply_hint <= bank_power_and_enable_control[`BIT_BANK_B_SUPPLY_HINT];
    end
  end
endmodule

// >>> rtl/glitchless_ref_mux.v
// reference source multiplexer for one bank divider, forced or glitch-less switching
`timescale 1ns/1ps
`include "fanout_ctrl_regs.vh"
module glitchless_ref_mux
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_ref_zero,
  input wire i_ref_one,
  input wire i_want_one,
  input wire i_glitchless,
  output reg o_ref_clk,
  output reg o_on_one
);
  reg prev_zero;
  reg prev_one;
  reg on_one;
  reg gap;
  wire fall_zero;
  wire fall_one;
  wire cur_fell;
  wire new_fell;
  wire next_ref;

  assign fall_zero = prev_zero & ~i_ref_zero;
  assign fall_one = prev_one & ~i_ref_one;
  assign cur_fell = on_one ? fall_one : fall_zero;
  assign new_fell = on_one ? fall_zero : fall_one;
  // while in the gap the output is parked low, so no shortened pulse escapes
  assign next_ref = gap ? 1'b0 : (on_one ? i_ref_one : i_ref_zero);

  // switch state: forced mode jumps at once, glitch-less mode waits on both falling edges
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_zero <= 1'b0;
      prev_one <= 1'b0;
      on_one <= 1'b0;
      gap <= 1'b0;
      o_ref_clk <= 1'b0;
      o_on_one <= 1'b0;
    end
    else
    begin
      prev_zero <= i_ref_zero;
      prev_one <= i_ref_one;
      o_ref_clk <= next_ref;
      o_on_one <= on_one;
      if (!i_glitchless)
      begin
        on_one <= i_want_one;
        gap <= 1'b0;
      end
      else if (!gap && (on_one != i_want_one) && cur_fell)
        gap <= 1'b1;
      else if (gap && (on_one == i_want_one))
        gap <= 1'b0; // selection returned before the switch completed
      else if (gap && new_fell)
      begin
        on_one <= i_want_one;
        gap <= 1'b0;
      end
    end
  end
endmodule
